// >>> rtl/pin_steer_pkg.sv
package pin_steer_pkg;

    localparam int PORT_N = 3;
    localparam int PORT_W = 8;
    localparam int PIN_N = PORT_N * PORT_W;
    localparam int PIN_IDX_W = 5;
    localparam int ADDR_W = 6;
    localparam int FN_N = 8;

    // Byte offsets: each port owns a block of four registers, then the two select registers.
    localparam logic [ADDR_W-1:0] PORT_A_BASE = 6'h00;
    localparam logic [ADDR_W-1:0] PORT_B_BASE = 6'h10;
    localparam logic [ADDR_W-1:0] PORT_C_BASE = 6'h20;
    localparam logic [ADDR_W-1:0] ALT_PIN_SELECT_0_OFS = 6'h30;
    localparam logic [ADDR_W-1:0] ALT_PIN_SELECT_1_OFS = 6'h34;
    localparam logic [1:0] DIRECTION_REG_IDX = 2'h0;
    localparam logic [1:0] PIN_LEVEL_REG_IDX = 2'h1;
    localparam logic [1:0] OUTPUT_LATCH_REG_IDX = 2'h2;
    localparam logic [1:0] ANALOG_SELECT_REG_IDX = 2'h3;
    localparam logic [1:0] SELECT_BLOCK_IDX = 2'h3;

    localparam logic [7:0] DIRECTION_RST = 8'hFF;
    localparam logic [7:0] OUTPUT_LATCH_RST = 8'h00;
    localparam logic [7:0] ANALOG_SELECT_RST = 8'hFF;
    localparam logic [7:0] ALT_PIN_SELECT_RST = 8'h00;

    // Implemented, drivable and analog-capable bits per port.
    localparam logic [7:0] PORT_A_IMPL = 8'h3F;
    localparam logic [7:0] PORT_A_OUT = 8'h37;
    localparam logic [7:0] PORT_A_ANALOG = 8'h17;
    localparam logic [7:0] PORT_B_IMPL = 8'hF0;
    localparam logic [7:0] PORT_C_IMPL = 8'hFF;

    // Writable bits of the select registers per package variant.
    localparam logic [7:0] SEL0_WR_SMALL = 8'hEC;
    localparam logic [7:0] SEL0_WR_LARGE = 8'h8C;
    localparam logic [7:0] SEL1_WR_SMALL = 8'h0F;
    localparam logic [7:0] SEL1_WR_LARGE = 8'h3F;

    localparam int SERIAL_RX_ROUTE_BIT = 7;
    localparam int SPI1_OUT_ROUTE_BIT = 6;
    localparam int SPI1_SELECT_ROUTE_BIT = 5;
    localparam int TIMER1_GATE_ROUTE_BIT = 3;
    localparam int SERIAL_TX_ROUTE_BIT = 2;
    localparam int SPI2_OUT_ROUTE_BIT = 5;
    localparam int SPI2_SELECT_ROUTE_BIT = 4;
    localparam int PWM1_D_ROUTE_BIT = 3;
    localparam int PWM1_C_ROUTE_BIT = 2;
    localparam int PWM2_B_ROUTE_BIT = 1;
    localparam int CAPTURE2_ROUTE_BIT = 0;

    // Flat pin numbering: port A 0..7, port B 8..15, port C 16..23.
    localparam logic [PIN_IDX_W-1:0] PORT_A_BIT0 = 5'h00;
    localparam logic [PIN_IDX_W-1:0] PORT_A_BIT1 = 5'h01;
    localparam logic [PIN_IDX_W-1:0] PORT_A_BIT3 = 5'h03;
    localparam logic [PIN_IDX_W-1:0] PORT_A_BIT4 = 5'h04;
    localparam logic [PIN_IDX_W-1:0] PORT_A_BIT5 = 5'h05;
    localparam logic [PIN_IDX_W-1:0] PORT_B_BIT5 = 5'h0D;
    localparam logic [PIN_IDX_W-1:0] PORT_B_BIT7 = 5'h0F;
    localparam logic [PIN_IDX_W-1:0] PORT_C_BIT0 = 5'h10;
    localparam logic [PIN_IDX_W-1:0] PORT_C_BIT1 = 5'h11;
    localparam logic [PIN_IDX_W-1:0] PORT_C_BIT2 = 5'h12;
    localparam logic [PIN_IDX_W-1:0] PORT_C_BIT3 = 5'h13;
    localparam logic [PIN_IDX_W-1:0] PORT_C_BIT4 = 5'h14;
    localparam logic [PIN_IDX_W-1:0] PORT_C_BIT5 = 5'h15;
    localparam logic [PIN_IDX_W-1:0] PORT_C_BIT6 = 5'h16;
    localparam logic [PIN_IDX_W-1:0] PORT_C_BIT7 = 5'h17;

    // Output functions, highest pin priority first.
    localparam int FN_SPI1_OUT = 0;
    localparam int FN_SPI2_OUT = 1;
    localparam int FN_SERIAL_TX = 2;
    localparam int FN_SERIAL_RX = 3;
    localparam int FN_PWM1_D = 4;
    localparam int FN_PWM1_C = 5;
    localparam int FN_PWM2_B = 6;
    localparam int FN_CAPTURE2 = 7;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// >>> rtl/port_latch_and_alt_pin_steering.sv
// Design decisions made here: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
// Behaviour
// - Each port has direction, pin-level, latch registers.
// - Pin-level write updates the output latch.
// - Latch reads latch; pin-level reads sampled pins.
// - Enabled peripheral replaces latch on pin output.
// - Analog select disables the digital input.
// - Select bits never touch direction; overrides follow.
// - Select0 bit7 routes serial receive/data.
// - Small: select0 bit6 routes spi1 data out.
// - Small: select0 bit5 routes spi1 slave select.
// - Select0 bit3 routes timer1 gate input.
// - Select0 bit2 routes serial transmit/clock.
// - Unimplemented select bits read zero.
// - Large: select1 bit5 routes spi2 data out.
// - Large: select1 bit4 routes spi2 slave select.
// - Select1 bit3 routes pwm1 output d.
// - Select1 bit2 routes pwm1 output c.
// - Select1 bit1 routes pwm2 output b.
// - Select1 bit0 routes capture2/pwm2 output a.
// - Direction one is input; zero drives latch.
// - Analog pins read zero through pin level.
// - Highest priority enabled function owns pin.
module port_latch_and_alt_pin_steering
    import pin_steer_pkg::*;
#(
    parameter bit LARGE_VARIANT = 1'b1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic [PIN_N-1:0] pin_in,
    output logic [PIN_N-1:0] pin_out,
    output logic [PIN_N-1:0] pin_oe_n,
    input wire logic spi1_data_out_en,
    input wire logic spi1_data_out,
    input wire logic spi2_data_out_en,
    input wire logic spi2_data_out,
    input wire logic serial_transmit_clock_en,
    input wire logic serial_transmit_clock_out,
    input wire logic serial_receive_data_en,
    input wire logic serial_receive_data_out,
    input wire logic pwm1_output_d_en,
    input wire logic pwm1_output_d,
    input wire logic pwm1_output_c_en,
    input wire logic pwm1_output_c,
    input wire logic pwm2_output_b_en,
    input wire logic pwm2_output_b,
    input wire logic capture2_pwm2_output_a_en,
    input wire logic capture2_pwm2_output_a,
    output logic serial_receive_data_in,
    output logic serial_transmit_clock_in,
    output logic spi1_slave_select_n,
    output logic spi2_slave_select_n,
    output logic timer1_gate_input,
    output logic capture2_in
);

    logic [7:0] direction_r [PORT_N];
    logic [7:0] output_latch_r [PORT_N];
    logic [7:0] analog_select_r [PORT_N];
    logic [7:0] alt_pin_select_0_r;
    logic [7:0] alt_pin_select_1_r;
    logic [7:0] impl_m [PORT_N];
    logic [7:0] out_m [PORT_N];
    logic [7:0] ana_m [PORT_N];
    logic [7:0] sel0_wr_m;
    logic [7:0] sel1_wr_m;

    logic [PIN_N-1:0] pin_meta_r;
    logic [PIN_N-1:0] pin_sync_r;
    logic [PIN_N-1:0] pin_level;
    logic [PIN_N-1:0] dir_flat;
    logic [PIN_N-1:0] latch_flat;
    logic [PIN_N-1:0] out_flat;
    logic [PIN_N-1:0] pin_out_nxt;
    logic [PIN_N-1:0] pin_oe_n_nxt;

    logic [FN_N-1:0] fn_en;
    logic [FN_N-1:0] fn_dat;
    logic [PIN_IDX_W-1:0] fn_pin [FN_N];
    logic [PIN_IDX_W-1:0] spi1_ss_pin;
    logic [PIN_IDX_W-1:0] spi2_ss_pin;
    logic [PIN_IDX_W-1:0] timer1_gate_pin;

    logic aw_hold_r;
    logic w_hold_r;
    logic [ADDR_W-1:0] awaddr_r;
    logic [7:0] wdata_r;
    logic wstrb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic [7:0] rd_byte;

    // Port masks; port B exists only on the large package.
    assign impl_m[0] = PORT_A_IMPL;
    assign impl_m[1] = LARGE_VARIANT ? PORT_B_IMPL : 8'h00;
    assign impl_m[2] = PORT_C_IMPL;
    assign out_m[0] = PORT_A_OUT;
    assign out_m[1] = impl_m[1];
    assign out_m[2] = PORT_C_IMPL;
    assign ana_m[0] = PORT_A_ANALOG;
    assign ana_m[1] = impl_m[1];
    assign ana_m[2] = PORT_C_IMPL;
    assign sel0_wr_m = LARGE_VARIANT ? SEL0_WR_LARGE : SEL0_WR_SMALL;
    assign sel1_wr_m = LARGE_VARIANT ? SEL1_WR_LARGE : SEL1_WR_SMALL;

    assign dir_flat = {direction_r[2], direction_r[1], direction_r[0]};
    assign latch_flat = {output_latch_r[2], output_latch_r[1], output_latch_r[0]};
    assign out_flat = {out_m[2], out_m[1], out_m[0]};
    // Analog pins have their digital input buffer off, so they read zero.
    assign pin_level = pin_sync_r & ~{analog_select_r[2], analog_select_r[1], analog_select_r[0]}
        & {impl_m[2], impl_m[1], impl_m[0]};

    // AXI4-Lite write channel.
    logic wr_go;
    logic [1:0] wr_blk;
    logic [1:0] wr_idx;
    logic wr_port_hit;
    logic wr_sel_hit;
    logic wr_lane;
    assign awready = ~aw_hold_r;
    assign wready = ~w_hold_r;
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign wr_go = aw_hold_r & w_hold_r & ~bvalid_r;
    assign wr_blk = awaddr_r[5:4];
    assign wr_idx = awaddr_r[3:2];
    assign wr_port_hit = wr_blk != SELECT_BLOCK_IDX;
    assign wr_sel_hit = (wr_blk == SELECT_BLOCK_IDX) && (wr_idx[1] == 1'b0);
    assign wr_lane = wr_go & wstrb_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= 8'h00;
            wstrb_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else begin
            if (awvalid && !aw_hold_r) begin
                aw_hold_r <= 1'b1;
                awaddr_r <= awaddr;
            end
            if (wvalid && !w_hold_r) begin
                w_hold_r <= 1'b1;
                wdata_r <= wdata[7:0];
                wstrb_r <= wstrb[0];
            end
            if (wr_go) begin
                aw_hold_r <= 1'b0;
                w_hold_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= (wr_port_hit || wr_sel_hit) ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_r && bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // Register file.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int p = 0; p < PORT_N; p++) begin
                direction_r[p] <= DIRECTION_RST;
                output_latch_r[p] <= OUTPUT_LATCH_RST;
                analog_select_r[p] <= ANALOG_SELECT_RST;
            end
            alt_pin_select_0_r <= ALT_PIN_SELECT_RST;
            alt_pin_select_1_r <= ALT_PIN_SELECT_RST;
        end else begin
            for (int p = 0; p < PORT_N; p++) begin
                analog_select_r[p] <= analog_select_r[p] & ana_m[p];
                if (wr_lane && wr_port_hit && wr_blk == 2'(p)) begin
                    if (wr_idx == DIRECTION_REG_IDX) begin
                        direction_r[p] <= wdata_r | ~out_m[p];
                    end
                    if (wr_idx == PIN_LEVEL_REG_IDX || wr_idx == OUTPUT_LATCH_REG_IDX) begin
                        output_latch_r[p] <= wdata_r & out_m[p];
                    end
                    if (wr_idx == ANALOG_SELECT_REG_IDX) begin
                        analog_select_r[p] <= wdata_r & ana_m[p];
                    end
                end
            end
            if (wr_lane && wr_sel_hit && wr_idx == 2'h0) begin
                alt_pin_select_0_r <= wdata_r & sel0_wr_m;
            end
            if (wr_lane && wr_sel_hit && wr_idx == 2'h1) begin
                alt_pin_select_1_r <= wdata_r & sel1_wr_m;
            end
        end
    end

    // AXI4-Lite read channel.
    logic [1:0] rd_blk;
    logic [1:0] rd_idx;
    logic rd_hit;
    assign arready = ~rvalid_r;
    assign rvalid = rvalid_r;
    assign rdata = rdata_r;
    assign rresp = rresp_r;
    assign rd_blk = araddr[5:4];
    assign rd_idx = araddr[3:2];
    assign rd_hit = (rd_blk != SELECT_BLOCK_IDX) || (rd_idx[1] == 1'b0);

    always_comb begin
        rd_byte = 8'h00;
        if (rd_blk == SELECT_BLOCK_IDX) begin
            rd_byte = (rd_idx == 2'h0) ? alt_pin_select_0_r : alt_pin_select_1_r;
        end else begin
            case (rd_idx)
                DIRECTION_REG_IDX: rd_byte = direction_r[rd_blk] & impl_m[rd_blk];
                PIN_LEVEL_REG_IDX: rd_byte = pin_level[rd_blk*PORT_W +: PORT_W];
                OUTPUT_LATCH_REG_IDX: rd_byte = output_latch_r[rd_blk];
                ANALOG_SELECT_REG_IDX: rd_byte = analog_select_r[rd_blk];
                default: rd_byte = 8'h00;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= RESP_OKAY;
        end else if (arvalid && !rvalid_r) begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_hit ? {24'h000000, rd_byte} : 32'h0000_0000;
            rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_r && rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // Output function steering; the spi2 peripheral is absent on the small package.
    assign fn_en = {capture2_pwm2_output_a_en, pwm2_output_b_en, pwm1_output_c_en, pwm1_output_d_en,
        serial_receive_data_en, serial_transmit_clock_en, spi2_data_out_en & LARGE_VARIANT, spi1_data_out_en};
    assign fn_dat = {capture2_pwm2_output_a, pwm2_output_b, pwm1_output_c, pwm1_output_d,
        serial_receive_data_out, serial_transmit_clock_out, spi2_data_out, spi1_data_out};

    assign fn_pin[FN_SPI1_OUT] = LARGE_VARIANT ? PORT_C_BIT7
        : (alt_pin_select_0_r[SPI1_OUT_ROUTE_BIT] ? PORT_A_BIT4 : PORT_C_BIT2);
    assign fn_pin[FN_SPI2_OUT] = alt_pin_select_1_r[SPI2_OUT_ROUTE_BIT] ? PORT_A_BIT5 : PORT_C_BIT1;
    assign fn_pin[FN_SERIAL_TX] = LARGE_VARIANT
        ? (alt_pin_select_0_r[SERIAL_TX_ROUTE_BIT] ? PORT_C_BIT4 : PORT_B_BIT7)
        : (alt_pin_select_0_r[SERIAL_TX_ROUTE_BIT] ? PORT_A_BIT0 : PORT_C_BIT4);
    assign fn_pin[FN_SERIAL_RX] = LARGE_VARIANT
        ? (alt_pin_select_0_r[SERIAL_RX_ROUTE_BIT] ? PORT_C_BIT5 : PORT_B_BIT5)
        : (alt_pin_select_0_r[SERIAL_RX_ROUTE_BIT] ? PORT_A_BIT1 : PORT_C_BIT5);
    assign fn_pin[FN_PWM1_D] = alt_pin_select_1_r[PWM1_D_ROUTE_BIT] ? PORT_C_BIT0 : PORT_C_BIT2;
    assign fn_pin[FN_PWM1_C] = alt_pin_select_1_r[PWM1_C_ROUTE_BIT] ? PORT_C_BIT1 : PORT_C_BIT3;
    assign fn_pin[FN_PWM2_B] = alt_pin_select_1_r[PWM2_B_ROUTE_BIT] ? PORT_A_BIT4 : PORT_C_BIT2;
    assign fn_pin[FN_CAPTURE2] = alt_pin_select_1_r[CAPTURE2_ROUTE_BIT] ? PORT_A_BIT5 : PORT_C_BIT3;

    assign spi1_ss_pin = LARGE_VARIANT ? PORT_C_BIT6
        : (alt_pin_select_0_r[SPI1_SELECT_ROUTE_BIT] ? PORT_A_BIT3 : PORT_C_BIT3);
    assign spi2_ss_pin = alt_pin_select_1_r[SPI2_SELECT_ROUTE_BIT] ? PORT_A_BIT4 : PORT_C_BIT0;
    assign timer1_gate_pin = alt_pin_select_0_r[TIMER1_GATE_ROUTE_BIT] ? PORT_A_BIT3 : PORT_A_BIT4;

    // Each pin takes the highest-priority enabled function aimed at it, else its latch.
    // The driver enable comes only from the direction bits, whatever the selects say.
    for (genvar p = 0; p < PIN_N; p++) begin : g_pin
        logic own_dat;
        always_comb begin
            own_dat = latch_flat[p];
            for (int f = FN_N - 1; f >= 0; f--) begin
                if (fn_en[f] && fn_pin[f] == PIN_IDX_W'(p)) begin
                    own_dat = fn_dat[f];
                end
            end
        end
        assign pin_out_nxt[p] = own_dat & out_flat[p];
        assign pin_oe_n_nxt[p] = dir_flat[p] | ~out_flat[p];
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_meta_r <= '0;
            pin_sync_r <= '0;
            pin_out <= '0;
            pin_oe_n <= '1;
            serial_receive_data_in <= 1'b0;
            serial_transmit_clock_in <= 1'b0;
            spi1_slave_select_n <= 1'b1;
            spi2_slave_select_n <= 1'b1;
            timer1_gate_input <= 1'b0;
            capture2_in <= 1'b0;
        end else begin
            pin_meta_r <= pin_in;
            pin_sync_r <= pin_meta_r;
            pin_out <= pin_out_nxt;
            pin_oe_n <= pin_oe_n_nxt;
            serial_receive_data_in <= pin_level[fn_pin[FN_SERIAL_RX]];
            serial_transmit_clock_in <= pin_level[fn_pin[FN_SERIAL_TX]];
            spi1_slave_select_n <= pin_level[spi1_ss_pin];
            spi2_slave_select_n <= LARGE_VARIANT ? pin_level[spi2_ss_pin] : 1'b1;
            timer1_gate_input <= pin_level[timer1_gate_pin];
            capture2_in <= pin_level[fn_pin[FN_CAPTURE2]];
        end
    end

endmodule

// >>> verification/pin_steer_checker.sv
`timescale 1ns/100ps
module pin_steer_checker
    import pin_steer_pkg::*;
#(
    parameter bit LARGE_VARIANT = 1'b1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [PIN_N-1:0] pin_out,
    input wire logic [PIN_N-1:0] pin_oe_n,
    input wire logic spi1_data_out_en,
    input wire logic spi1_data_out
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence wr_take;
        awvalid && awready && wvalid && wready;
    endsequence
    sequence wr_unmapped;
        wr_take ##0 (awaddr >= 6'h38);
    endsequence

    a_write_answer: assert property (wr_take |-> ##[1:2] bvalid)
        else $error("write response missing");
    a_unmapped_err: assert property (wr_unmapped |-> ##[1:2] (bvalid && bresp == RESP_SLVERR))
        else $error("unmapped write not refused");
    a_bresp_stands: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped early");
    a_read_answer: assert property (arvalid && arready |=> rvalid)
        else $error("read answer late");
    a_rdata_stands: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data not held");
    a_rdata_upper: assert property (rvalid |-> rdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_addr_held: assert property (awvalid && awready |=> !awready)
        else $error("second address taken");
    a_input_only: assert property (pin_oe_n[PORT_A_BIT3] && pin_oe_n[11:8] == 4'hF)
        else $error("input only pin driven");
    a_spi1_fixed: assert property (LARGE_VARIANT && spi1_data_out_en |=> pin_out[PORT_C_BIT7] == $past(spi1_data_out))
        else $error("spi1 output not on its pin");
    a_reset_idle: assert property ($rose(aresetn) |-> !bvalid && !rvalid && (&pin_oe_n))
        else $error("outputs not idle after reset");
endmodule

bind port_latch_and_alt_pin_steering pin_steer_checker #(.LARGE_VARIANT(LARGE_VARIANT)) chk (.aclk(aclk),
    .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rvalid(rvalid), .rready(rready), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .spi1_data_out_en(spi1_data_out_en), .spi1_data_out(spi1_data_out));

// >>> verification/board_model.sv
`timescale 1ns/100ps
module board_model
    import pin_steer_pkg::*;
(
    input wire logic [PIN_N-1:0] pin_out,
    input wire logic [PIN_N-1:0] pin_oe_n,
    input wire logic [PIN_N-1:0] ext_level,
    output logic [PIN_N-1:0] pin_in
);
    // A driven pin shows the device's level; an undriven pin shows what the board applies.
    assign pin_in = (pin_out & ~pin_oe_n) | (ext_level & pin_oe_n);
endmodule

// >>> verification/tb_port_latch_and_alt_pin_steering.sv
`timescale 1ns/100ps
module tb_port_latch_and_alt_pin_steering
    import pin_steer_pkg::*;
;
    logic aclk, awready, wready, bvalid, arready, rvalid, rx_in, tx_in, ss1_n, ss2_n, t1g, c2_in;
    logic aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic s1_en = 1'h0, s1_d = 1'h0, s2_en = 1'h0, s2_d = 1'h0, tx_en = 1'h0, tx_d = 1'h0, rx_en = 1'h0;
    logic rx_d = 1'h0, p1d_en = 1'h0, p1d = 1'h0, p1c_en = 1'h0, p1c = 1'h0, p2b_en = 1'h0, p2b = 1'h0;
    logic c2_en = 1'h0, c2 = 1'h0;
    logic [ADDR_W-1:0] awaddr = 6'h00, araddr = 6'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0] bresp, rresp;
    logic [PIN_N-1:0] pin_in, pin_out, pin_oe_n, ext = 24'h0;
    logic s_rx, s_tx, s_ss1, s_ss2, s_t1g, s_c2;
    logic [7:0] sel1_tab [3] = '{8'h00, 8'h0F, 8'h2F};
    logic [7:0] out_tab [3] = '{8'h37, 8'h0F, 8'h2D};
    int miscompares = 0;
    int tests_run = 0;

    port_latch_and_alt_pin_steering #(.LARGE_VARIANT(1'b1)) dut (.aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .spi1_data_out_en(s1_en),
        .spi1_data_out(s1_d), .spi2_data_out_en(s2_en), .spi2_data_out(s2_d), .serial_transmit_clock_en(tx_en),
        .serial_transmit_clock_out(tx_d), .serial_receive_data_en(rx_en), .serial_receive_data_out(rx_d),
        .pwm1_output_d_en(p1d_en), .pwm1_output_d(p1d), .pwm1_output_c_en(p1c_en), .pwm1_output_c(p1c),
        .pwm2_output_b_en(p2b_en), .pwm2_output_b(p2b), .capture2_pwm2_output_a_en(c2_en),
        .capture2_pwm2_output_a(c2), .serial_receive_data_in(rx_in), .serial_transmit_clock_in(tx_in),
        .spi1_slave_select_n(ss1_n), .spi2_slave_select_n(ss2_n), .timer1_gate_input(t1g), .capture2_in(c2_in));

    board_model board (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_level(ext), .pin_in(pin_in));

    // A small-package twin shares the bus; its pins see only the board levels and its steered inputs are compared.
    port_latch_and_alt_pin_steering #(.LARGE_VARIANT(1'b0)) dut_small (.aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(), .wdata(wdata), .wstrb(4'hF),
        .wvalid(wvalid), .wready(), .bresp(), .bvalid(), .bready(bready), .araddr(araddr), .arprot(3'h0),
        .arvalid(arvalid), .arready(), .rdata(), .rresp(), .rvalid(), .rready(rready), .pin_in(ext),
        .pin_out(), .pin_oe_n(), .spi1_data_out_en(s1_en), .spi1_data_out(s1_d), .spi2_data_out_en(s2_en),
        .spi2_data_out(s2_d), .serial_transmit_clock_en(tx_en), .serial_transmit_clock_out(tx_d),
        .serial_receive_data_en(rx_en), .serial_receive_data_out(rx_d), .pwm1_output_d_en(p1d_en),
        .pwm1_output_d(p1d), .pwm1_output_c_en(p1c_en), .pwm1_output_c(p1c), .pwm2_output_b_en(p2b_en),
        .pwm2_output_b(p2b), .capture2_pwm2_output_a_en(c2_en), .capture2_pwm2_output_a(c2),
        .serial_receive_data_in(s_rx), .serial_transmit_clock_in(s_tx), .spi1_slave_select_n(s_ss1),
        .spi2_slave_select_n(s_ss2), .timer1_gate_input(s_t1g), .capture2_in(s_c2));

    initial begin
        aclk = 1'h0;
        forever #12.5 aclk = ~aclk;
    end

    always @(posedge aclk) s1_d <= ~s1_d;

    task automatic check(input logic [33:0] got, input logic [33:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Address and data are offered together; each is released at the edge that takes it.
    task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic [1:0] er);
        logic ta, tw, done;
        logic [1:0] rs;
        int n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        n = 0;
        done = 1'h0;
        while (!done && n < 100) begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            done = bvalid;
            rs = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'h0;
            if (tw) wvalid <= 1'h0;
            n++;
        end
        bready <= 1'h0;
        check({32'h0, rs}, {32'h0, er});
    endtask

    task automatic rd(input logic [5:0] a, input logic [7:0] e, input logic [1:0] er);
        logic ta, done;
        logic [33:0] got;
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        n = 0;
        done = 1'h0;
        while (!done && n < 100) begin
            @(negedge aclk);
            ta = arvalid && arready;
            done = rvalid;
            got = {rresp, rdata};
            @(posedge aclk);
            if (ta) arvalid <= 1'h0;
            n++;
        end
        rready <= 1'h0;
        check(got, {er, 24'h0, e});
    endtask

    initial begin
        repeat (20000) @(posedge aclk);
        miscompares++;
        complete_run();
    end

    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        rd(6'h00, 8'h3F, RESP_OKAY);
        rd(6'h10, 8'hF0, RESP_OKAY);
        rd(6'h0C, 8'h17, RESP_OKAY);
        rd(6'h28, 8'h00, RESP_OKAY);
        rd(6'h38, 8'h00, RESP_SLVERR);
        wr(6'h3C, 8'hFF, RESP_SLVERR);
        wr(6'h30, 8'hFF, RESP_OKAY);
        rd(6'h30, 8'h8C, RESP_OKAY);
        wr(6'h34, 8'hFF, RESP_OKAY);
        rd(6'h34, 8'h3F, RESP_OKAY);
        wr(6'h0C, 8'h00, RESP_OKAY);
        wr(6'h1C, 8'h00, RESP_OKAY);
        wr(6'h2C, 8'h00, RESP_OKAY);
        ext <= 24'h582010;
        for (int i = 0; i < 2; i++) begin
            wr(6'h30, i ? 8'h00 : 8'h8C, RESP_OKAY);
            wr(6'h34, i ? 8'h00 : 8'h11, RESP_OKAY);
            repeat (4) @(posedge aclk);
            check({28'h0, rx_in, tx_in, t1g, c2_in, ss2_n, ss1_n}, i ? 34'h2D : 34'h13);
            check({28'h0, s_rx, s_tx, s_t1g, s_c2, s_ss2, s_ss1}, i ? 34'h1F : 34'h03);
        end
        wr(6'h00, 8'h00, RESP_OKAY);
        wr(6'h04, 8'h15, RESP_OKAY);
        rd(6'h08, 8'h15, RESP_OKAY);
        ext[3] <= 1'h1;
        repeat (4) @(posedge aclk);
        rd(6'h04, 8'h1D, RESP_OKAY);
        wr(6'h0C, 8'h17, RESP_OKAY);
        repeat (4) @(posedge aclk);
        rd(6'h04, 8'h08, RESP_OKAY);
        wr(6'h08, 8'h22, RESP_OKAY);
        repeat (4) @(posedge aclk);
        rd(6'h04, 8'h28, RESP_OKAY);
        wr(6'h08, 8'hFF, RESP_OKAY);
        wr(6'h18, 8'hFF, RESP_OKAY);
        wr(6'h28, 8'hFF, RESP_OKAY);
        {s1_en, s2_en, s2_d, tx_en, rx_en, p1d_en, p1d, p1c_en, p2b_en, c2_en} <= 10'h3FF;
        for (int k = 0; k < 3; k++) begin
            wr(6'h34, sel1_tab[k], RESP_OKAY);
            repeat (2) @(posedge aclk);
            check({26'h0, pin_out[15], pin_out[13], pin_out[5:4], pin_out[19:16]}, {26'h0, out_tab[k]});
            check({10'h0, pin_oe_n}, {10'h0, 24'hFFFFC8});
        end
        aresetn <= 1'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        rd(6'h34, 8'h00, RESP_OKAY);
        complete_run();
    end
endmodule
